/* rtl/esw_pkg.sv */
package esw_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam int unsigned AGE_LIMIT_S   = 300;
  localparam int unsigned LINK_LOSS_MS  = 100;
  localparam int unsigned LINK_LOSS_CYC = CLK_HZ / 1000 * LINK_LOSS_MS;
  localparam int unsigned XOVER_MS      = 60;
  localparam int unsigned XOVER_CYC     = CLK_HZ / 1000 * XOVER_MS;
  // ----------------------------------------------------------------
  // frame checks
  // ----------------------------------------------------------------
  localparam int unsigned MAX_FRAME_BYTES = 1522;
  localparam int unsigned MIN_FRAME_BYTES = 64;
  localparam int unsigned BUF_BYTES       = 2048;
  localparam int unsigned DA_END          = 6;
  localparam int unsigned SA_END          = 12;
  localparam int unsigned TPID_END        = 14;
  localparam logic [31:0] CRC_INIT        = 32'hffffffff;
  localparam logic [31:0] CRC_POLY        = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE     = 32'hdebb20e3;
  localparam logic [15:0] VLAN_TPID       = 16'h8100;
  // ----------------------------------------------------------------
  // ports and address table
  // ----------------------------------------------------------------
  localparam int unsigned NPORTS      = 8;
  localparam int unsigned TABLE_DEPTH = 1024;
  localparam int unsigned FIFO_DEPTH  = 8;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_CHECK, ST_LEARN, ST_FWD, ST_TX
  } esw_state_type;
endpackage : esw_pkg

/* rtl/esw_switch_core.sv */
`timescale 1ns/1ps
module esw_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end

  // ready is registered so the source sees back-pressure from a flop
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wp_r     <= '0;
      rp_r     <= '0;
      cnt_r    <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      wp_r     <= wp_r + AW'(push);
      rp_r     <= rp_r + AW'(pop);
      cnt_r    <= cnt_nxt;
      in_ready <= (cnt_nxt < (AW+1)'(DEPTH));
    end
  end
endmodule : esw_fifo

module esw_switch_core #(
  parameter int unsigned SEC_CYC       = esw_pkg::SEC_CYC,
  parameter int unsigned LINK_LOSS_CYC = esw_pkg::LINK_LOSS_CYC,
  parameter int unsigned XOVER_CYC     = esw_pkg::XOVER_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] rx_valid,
  input  wire logic [7:0] rx_last,
  input  wire logic [7:0][7:0] rx_data,
  output logic      [7:0] rx_ready,
  input  wire logic [7:0] link_pulse_pin,
  input  wire logic [7:0] rx_pol_pin,
  output logic      [7:0] link_up,
  output logic      [7:0] rx_invert,
  output logic      [7:0] mdix_sel,
  output logic            tx_valid,
  output logic      [7:0] tx_data,
  output logic            tx_last,
  output logic      [7:0] tx_port_mask,
  output logic            tx_tagged,
  input  wire logic       tx_ready
);
  localparam int unsigned NP = esw_pkg::NPORTS;
  localparam int unsigned TD = esw_pkg::TABLE_DEPTH;

  function automatic logic [31:0] esw_crc8(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ esw_pkg::CRC_POLY) : (r >> 1);
    return r;
  endfunction : esw_crc8

  function automatic logic [9:0] esw_hash(input logic [47:0] m);
    return m[9:0] ^ m[19:10] ^ m[29:20] ^ m[39:30] ^ {2'b00, m[47:40]};
  endfunction : esw_hash

  function automatic logic esw_old(input logic [9:0] stamp,
                                   input logic [9:0] now);
    logic [9:0] age;
    age = now - stamp;
    return age > 10'(esw_pkg::AGE_LIMIT_S);
  endfunction : esw_old

  // lowest rotating distance from the last served port wins
  function automatic logic [3:0] esw_pick(input logic [7:0] v,
                                          input logic [2:0] last);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int k = 8; k >= 1; k--)
    begin
      idx = last + 3'(k);
      if (v[idx])
        res = {1'b1, idx};
    end
    return res;
  endfunction : esw_pick

  // ----------------------------------------------------------------
  // receive fifos
  // ----------------------------------------------------------------
  logic [7:0]      fifo_vld;
  logic [7:0]      fifo_pop;
  logic [7:0][8:0] fifo_out;

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_fifo
      esw_fifo #(.WIDTH(9), .DEPTH(esw_pkg::FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (rx_valid[gp]),
        .in_data   ({rx_last[gp], rx_data[gp]}),
        .in_ready  (rx_ready[gp]),
        .out_valid (fifo_vld[gp]),
        .out_data  (fifo_out[gp]),
        .out_ready (fifo_pop[gp])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // frame capture and check
  // ----------------------------------------------------------------
  esw_pkg::esw_state_type st_r;
  logic [7:0]  frame_mem [esw_pkg::BUF_BYTES];
  logic [2:0]  sel_r;
  logic [10:0] len_r;
  logic [31:0] crc_r;
  logic [47:0] da_r;
  logic [47:0] sa_r;
  logic [15:0] tpid_r;
  logic [3:0]  pick;
  logic        take;
  logic [7:0]  rx_byte;
  logic        rx_end;
  logic [7:0]  fwd_mask;

  assign pick    = esw_pick(fifo_vld, sel_r);
  assign take    = (st_r == esw_pkg::ST_RX) && fifo_vld[sel_r];
  assign rx_byte = fifo_out[sel_r][7:0];
  assign rx_end  = fifo_out[sel_r][8];

  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_pop
      assign fifo_pop[gp] = take && (sel_r == 3'(gp));
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (take && len_r != 11'h7ff)
      frame_mem[len_r] <= rx_byte;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_r   <= esw_pkg::ST_IDLE;
      sel_r  <= 3'h7;
      len_r  <= '0;
      crc_r  <= esw_pkg::CRC_INIT;
      da_r   <= '0;
      sa_r   <= '0;
      tpid_r <= '0;
    end
    else
    begin
      unique case (st_r)
        esw_pkg::ST_IDLE:
          if (pick[3])
          begin
            sel_r <= pick[2:0];
            len_r <= '0;
            crc_r <= esw_pkg::CRC_INIT;
            st_r  <= esw_pkg::ST_RX;
          end
        esw_pkg::ST_RX:
          if (take)
          begin
            // saturates; anything that long fails the size check anyway
            if (len_r != 11'h7ff)
              len_r <= len_r + 11'h001;
            crc_r <= esw_crc8(crc_r, rx_byte);
            if (len_r < 11'(esw_pkg::DA_END))
              da_r <= {da_r[39:0], rx_byte};
            else if (len_r < 11'(esw_pkg::SA_END))
              sa_r <= {sa_r[39:0], rx_byte};
            else if (len_r < 11'(esw_pkg::TPID_END))
              tpid_r <= {tpid_r[7:0], rx_byte};
            if (rx_end)
              st_r <= esw_pkg::ST_CHECK;
          end
        esw_pkg::ST_CHECK:
          if (len_r > 11'(esw_pkg::MAX_FRAME_BYTES) ||
              len_r < 11'(esw_pkg::MIN_FRAME_BYTES) ||
              crc_r != esw_pkg::CRC_RESIDUE)
            st_r <= esw_pkg::ST_IDLE;
          else
            st_r <= esw_pkg::ST_LEARN;
        esw_pkg::ST_LEARN:
          st_r <= esw_pkg::ST_FWD;
        esw_pkg::ST_FWD:
          // nowhere to send leaves the frame dropped
          st_r <= (fwd_mask == 8'h00) ? esw_pkg::ST_IDLE : esw_pkg::ST_TX;
        esw_pkg::ST_TX:
          if (tx_valid && tx_ready && tx_last)
            st_r <= esw_pkg::ST_IDLE;
        default:
          st_r <= esw_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // address table
  // ----------------------------------------------------------------
  logic [47:0]   tab_mac   [TD];
  logic [2:0]    tab_port  [TD];
  logic [9:0]    tab_stamp [TD];
  logic [TD-1:0] tab_vld_r;
  logic [9:0]    sweep_r;
  logic [9:0]    now_r;
  logic [31:0]   sec_cnt_r;
  logic [9:0]    sa_idx;
  logic [9:0]    da_idx;
  logic          learn_ok;
  logic          da_hit;

  assign sa_idx   = esw_hash(sa_r);
  assign da_idx   = esw_hash(da_r);
  // slot held by a live other address: skip learning
  assign learn_ok = !tab_vld_r[sa_idx] || tab_mac[sa_idx] == sa_r ||
                    esw_old(tab_stamp[sa_idx], now_r);
  assign da_hit   = tab_vld_r[da_idx] && tab_mac[da_idx] == da_r &&
                    !esw_old(tab_stamp[da_idx], now_r);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sec_cnt_r <= '0;
      now_r     <= '0;
    end
    else if (sec_cnt_r == SEC_CYC - 1)
    begin
      sec_cnt_r <= '0;
      now_r     <= now_r + 10'h001;
    end
    else
      sec_cnt_r <= sec_cnt_r + 32'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (st_r == esw_pkg::ST_LEARN && learn_ok)
    begin
      tab_mac[sa_idx]   <= sa_r;
      tab_port[sa_idx]  <= sel_r;
      tab_stamp[sa_idx] <= now_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tab_vld_r <= '0;
      sweep_r   <= '0;
    end
    else
    begin
      sweep_r <= sweep_r + 10'h001;
      if (esw_old(tab_stamp[sweep_r], now_r))
        tab_vld_r[sweep_r] <= 1'b0;
      // learning wins over a sweep of the same slot
      if (st_r == esw_pkg::ST_LEARN && learn_ok)
        tab_vld_r[sa_idx] <= 1'b1;
    end
  end

  // flood unknown and group, else the learned port only
  always_comb
  begin
    fwd_mask = 8'hff;
    if (!da_r[40] && da_hit)
      fwd_mask = 8'h01 << tab_port[da_idx];
    fwd_mask = fwd_mask & link_up & ~(8'h01 << sel_r);
  end

  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------
  logic [10:0] rptr_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rptr_r       <= '0;
      tx_valid     <= 1'b0;
      tx_data      <= '0;
      tx_last      <= 1'b0;
      tx_port_mask <= '0;
      tx_tagged    <= 1'b0;
    end
    else if (st_r == esw_pkg::ST_FWD)
    begin
      rptr_r       <= '0;
      tx_port_mask <= fwd_mask;
      tx_tagged    <= (tpid_r == esw_pkg::VLAN_TPID);
    end
    else if (st_r == esw_pkg::ST_TX && (!tx_valid || tx_ready))
    begin
      // a port losing link mid-frame is cut from the mask one cycle later
      tx_port_mask <= tx_port_mask & link_up;
      tx_valid     <= (rptr_r < len_r);
      tx_data      <= frame_mem[rptr_r];
      tx_last      <= (rptr_r == len_r - 11'h001);
      if (rptr_r < len_r)
        rptr_r <= rptr_r + 11'h001;
    end
    else
    begin
      tx_port_mask <= tx_port_mask & link_up;
      if (tx_ready)
        tx_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // link supervision, polarity, crossover
  // ----------------------------------------------------------------
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_link
      logic [1:0]  s1_r;
      logic [1:0]  s2_r;
      logic [1:0]  s3_r;
      logic [1:0]  stable_r;
      logic        pulse;
      logic [31:0] loss_cnt_r;
      logic [31:0] xo_cnt_r;

      // pin pair: {polarity sense, link pulse}
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          s1_r     <= '0;
          s2_r     <= '0;
          s3_r     <= '0;
          stable_r <= '0;
        end
        else
        begin
          s1_r <= {rx_pol_pin[gp], link_pulse_pin[gp]};
          s2_r <= s1_r;
          s3_r <= s2_r;
          for (int b = 0; b < 2; b++)
            if (s2_r[b] == s3_r[b])
              stable_r[b] <= s3_r[b];
        end
      end

      assign pulse = s2_r[0] && s3_r[0] && !stable_r[0];

      // silence past the loss time drops the link
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          loss_cnt_r  <= '0;
          link_up[gp] <= 1'b0;
        end
        else if (pulse)
        begin
          loss_cnt_r  <= '0;
          link_up[gp] <= 1'b1;
        end
        else if (loss_cnt_r == LINK_LOSS_CYC - 1)
          link_up[gp] <= 1'b0;
        else
          loss_cnt_r <= loss_cnt_r + 32'h1;
      end

      always_ff @(posedge core_clk)
      begin
        if (rst)
          rx_invert[gp] <= 1'b0;
        // sense pin is only high with the pulse, so take its agreed level
        // now rather than the last settled one, which is always low
        else if (pulse)
          rx_invert[gp] <= (s2_r[1] == s3_r[1]) ? s3_r[1] : stable_r[1];
      end

      // hunt pair assignment until pulses arrive
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          xo_cnt_r     <= '0;
          mdix_sel[gp] <= 1'b0;
        end
        else if (link_up[gp] || pulse)
          xo_cnt_r <= '0;
        else if (xo_cnt_r == XOVER_CYC - 1)
        begin
          xo_cnt_r     <= '0;
          mdix_sel[gp] <= !mdix_sel[gp];
        end
        else
          xo_cnt_r <= xo_cnt_r + 32'h1;
      end
    end
  endgenerate
endmodule : esw_switch_core

/* verification/esw_properties.sv */
`timescale 1ns/1ps
module esw_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] rx_ready,
  input wire logic [7:0] link_pulse_pin,
  input wire logic [7:0] link_up,
  input wire logic [7:0] rx_invert,
  input wire logic [7:0] mdix_sel,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_last,
  input wire logic [7:0] tx_port_mask,
  input wire logic       tx_tagged,
  input wire logic       tx_ready
);
  // ------------------------------------------------------------
  // recent pulse window
  // ------------------------------------------------------------
  logic [3:0] seen_r [8];
  logic [7:0] recent;
  // wide enough to cover the pin synchroniser delay
  always_ff @(posedge core_clk)
  begin
    for (int p = 0; p < 8; p++)
    begin
      if (link_pulse_pin[p])
        seen_r[p] <= 4'hc;
      else if (rst || seen_r[p] == 4'h0)
        seen_r[p] <= 4'h0;
      else
        seen_r[p] <= seen_r[p] - 4'h1;
    end
  end
  always_comb
  begin
    for (int p = 0; p < 8; p++)
      recent[p] = link_pulse_pin[p] || seen_r[p] != 4'h0;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_rst_idle;
    @(posedge core_clk) disable iff (1'b0)
    rst |=> link_up == 8'h00 && rx_ready == 8'h00 && !tx_valid
      && rx_invert == 8'h00 && mdix_sel == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("outputs not cleared by reset");
  property p_ready_back;
    $fell(rst) |-> rx_ready == 8'h00 ##1 rx_ready == 8'hff;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("rx_ready not restored after reset");
  property p_dead_port;
    tx_valid && link_up == $past(link_up) && link_up == $past(link_up, 2)
      |-> (tx_port_mask & ~link_up) == 8'h00;
  endproperty
  a_dead_port: assert property (p_dead_port)
    else $error("frame aimed at a port without link");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("tx byte changed while stalled");
  property p_no_grow;
    tx_valid && !(tx_ready && tx_last)
      |=> (tx_port_mask & ~$past(tx_port_mask)) == 8'h00;
  endproperty
  a_no_grow: assert property (p_no_grow)
    else $error("port mask gained a port mid frame");
  property p_mask_set;
    tx_valid |-> tx_port_mask != 8'h00;
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("frame sent with empty port mask");
  property p_tag_hold;
    tx_valid && !(tx_ready && tx_last) |=> $stable(tx_tagged);
  endproperty
  a_tag_hold: assert property (p_tag_hold)
    else $error("tag flag changed mid frame");
  property p_link_cause;
    (link_up & ~$past(link_up) & ~recent) == 8'h00;
  endproperty
  a_link_cause: assert property (p_link_cause)
    else $error("link came up without a pulse");
  property p_inv_cause;
    ((rx_invert ^ $past(rx_invert)) & ~recent) == 8'h00;
  endproperty
  a_inv_cause: assert property (p_inv_cause)
    else $error("polarity changed without a pulse");
  property p_mdix_hold;
    (link_up & $past(link_up) & (mdix_sel ^ $past(mdix_sel))) == 8'h00;
  endproperty
  a_mdix_hold: assert property (p_mdix_hold)
    else $error("pair swap moved on a live link");
endmodule : esw_props

bind esw_switch_core esw_props u_props (
  .core_clk(core_clk), .rst(rst), .rx_ready(rx_ready),
  .link_pulse_pin(link_pulse_pin), .link_up(link_up),
  .rx_invert(rx_invert), .mdix_sel(mdix_sel), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_port_mask(tx_port_mask),
  .tx_tagged(tx_tagged), .tx_ready(tx_ready)
);

/* verification/esw_station_model.sv */
`timescale 1ns/1ps
module esw_station_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] link_en,
  input  wire logic [7:0] pol_swap,
  input  wire logic       tx_hold,
  input  wire logic       tx_slow,
  output logic      [7:0] link_pulse_pin,
  output logic      [7:0] rx_pol_pin,
  output logic            tx_ready
);
  logic [5:0] tick_r = 6'h00;
  always_ff @(posedge core_clk)
  begin
    tick_r <= (tick_r == 6'h27) ? 6'h00 : tick_r + 6'h01;
  end
  assign link_pulse_pin = link_en & {8{tick_r < 6'h02}};
  // swapped pair seen as reversed pulse
  assign rx_pol_pin = pol_swap & link_pulse_pin;
  // slow sink takes a byte every other cycle
  assign tx_ready = !tx_hold && (!tx_slow || tick_r[0]);
endmodule : esw_station_model

/* verification/esw_switch_core_bench.sv */
`timescale 1ns/1ps
module esw_switch_core_bench;
  localparam logic [47:0] BC  = 48'hffffffffffff;
  localparam logic [47:0] SA0 = 48'h020000000001;
  localparam logic [47:0] STA = 48'h02000000000a;
  // lands in the same table slot as STA
  localparam logic [47:0] COL = 48'h02000000040b;
  logic            core_clk = 1'b0;
  logic            rst = 1'b1;
  logic [7:0]      rx_valid = 8'h00;
  logic [7:0]      rx_last = 8'h00;
  logic [7:0][7:0] rx_data = 64'h0;
  logic [7:0]      link_en = 8'h0f;
  logic [7:0]      pol_swap = 8'h04;
  logic            tx_hold = 1'b0;
  logic            tx_slow = 1'b0;
  logic [7:0]      rx_ready, link_pulse_pin, rx_pol_pin, link_up;
  logic [7:0]      rx_invert, mdix_sel, tx_data, tx_port_mask;
  logic            tx_valid, tx_last, tx_tagged, tx_ready;
  logic [7:0]      fr [$];
  logic [7:0]      got [$];
  logic [8:0]      gq [$];
  int              num_errors = 0;
  int              compares = 0;
  int              stalls = 0;

  always #12.5 core_clk = ~core_clk;

  esw_switch_core #(.SEC_CYC(10), .LINK_LOSS_CYC(200), .XOVER_CYC(50)) DUT (
    .core_clk(core_clk), .rst(rst), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_data(rx_data), .rx_ready(rx_ready),
    .link_pulse_pin(link_pulse_pin), .rx_pol_pin(rx_pol_pin),
    .link_up(link_up), .rx_invert(rx_invert), .mdix_sel(mdix_sel),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_port_mask(tx_port_mask), .tx_tagged(tx_tagged),
    .tx_ready(tx_ready));
  esw_station_model u_sta (
    .core_clk(core_clk), .link_en(link_en), .pol_swap(pol_swap),
    .tx_hold(tx_hold), .tx_slow(tx_slow),
    .link_pulse_pin(link_pulse_pin), .rx_pol_pin(rx_pol_pin),
    .tx_ready(tx_ready));

  always @(posedge core_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      got.push_back(tx_data);
      if (tx_last === 1'b1)
        gq.push_back({tx_tagged, tx_port_mask});
    end
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic end_sim;
    $display("errors %0d of %0d compares", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic mk(input logic [47:0] da, input logic [47:0] sa,
                    input int n, input logic tag);
    logic [31:0] c;
    fr.delete();
    for (int i = 47; i > 0; i -= 8)
      fr.push_back(da[i -: 8]);
    for (int i = 47; i > 0; i -= 8)
      fr.push_back(sa[i -: 8]);
    if (tag)
      fr = {fr, 8'h81, 8'h00, 8'h20, 8'h05};
    fr = {fr, 8'h08, 8'h00};
    while (fr.size() < n - 4)
      fr.push_back(8'(fr.size()));
    c = 32'hffffffff;
    foreach (fr[i])
    begin
      c = c ^ {24'h000000, fr[i]};
      repeat (8)
        c = c[0] ? (c >> 1) ^ esw_pkg::CRC_POLY : c >> 1;
    end
    for (int i = 0; i < 32; i += 8)
      fr.push_back(~c[i +: 8]);
  endtask : mk
  task automatic send(input int p);
    int k;
    foreach (fr[i])
    begin
      rx_valid[p] <= 1'b1;
      rx_data[p] <= fr[i];
      rx_last[p] <= (i == fr.size() - 1);
      k = 0;
      do
      begin
        @(posedge core_clk);
        k++;
        stalls += (rx_ready[p] !== 1'b1);
      end
      while (rx_ready[p] !== 1'b1 && k < 3000);
      if (k == 3000)
      begin
        chk(1'b0, "rx byte never taken");
        end_sim();
      end
    end
    rx_valid[p] <= 1'b0;
    rx_last[p] <= 1'b0;
  endtask : send
  task automatic wait_fr(output logic [8:0] g);
    int k;
    k = 0;
    while (gq.size() == 0 && k < 5000)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k == 5000)
    begin
      chk(1'b0, "no frame forwarded");
      end_sim();
    end
    g = gq.pop_front();
    chk(got.size() >= fr.size(), "short frame");
    foreach (fr[i])
      chk(got.size() > 0 && got.pop_front() === fr[i], "frame byte");
  endtask : wait_fr
  task automatic nofr;
    cyc(300);
    chk(gq.size() == 0 && got.size() == 0, "frame not dropped");
    gq.delete();
    got.delete();
  endtask : nofr
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_link;
    logic m;
    cyc(120);
    chk(link_up === 8'h0f, "link state");
    chk(rx_invert[3:0] === 4'h4, "polarity");
    m = mdix_sel[7];
    // one hunt period holds exactly one toggle
    cyc(50);
    chk(mdix_sel[7] !== m, "crossover hunt");
  endtask : t_link
  task automatic t_len;
    logic [8:0] g;
    int lens [4] = '{63, 64, 1522, 1523};
    for (int i = 0; i < 4; i++)
    begin
      mk(BC, SA0, lens[i], 1'b0);
      send(0);
      if (i == 1 || i == 2)
      begin
        wait_fr(g);
        chk(g === 9'h00e, "flood mask");
      end
      else
        nofr();
    end
    mk(BC, SA0, 80, 1'b0);
    fr[30] = ~fr[30];
    send(0);
    nofr();
  endtask : t_len
  task automatic t_learn;
    logic [8:0] g;
    mk(BC, STA, 64, 1'b0);
    send(1);
    wait_fr(g);
    chk(g === 9'h00d, "broadcast mask");
    mk(STA, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h002, "learned port");
    mk(48'h02000000000b, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h00e, "unknown floods");
    mk(48'h01005e000001, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h00e, "multicast floods");
    mk(BC, COL, 64, 1'b0);
    send(2);
    wait_fr(g);
    chk(g === 9'h00b, "full slot still forwards");
    mk(COL, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h00e, "unlearned address floods");
    mk(STA, STA, 64, 1'b0);
    send(1);
    nofr();
  endtask : t_learn
  task automatic t_tag;
    logic [8:0] g;
    tx_slow <= 1'b1;
    mk(STA, 48'h020000000003, 64, 1'b1);
    send(2);
    wait_fr(g);
    chk(g === 9'h102, "tagged frame");
    tx_slow <= 1'b0;
  endtask : t_tag
  task automatic t_fill;
    logic [8:0] g, h;
    tx_hold <= 1'b1;
    stalls = 0;
    mk(BC, SA0, 64, 1'b0);
    fork
      send(0);
      send(1);
      begin
        cyc(300);
        tx_hold <= 1'b0;
      end
    join
    chk(stalls > 0, "input never refused");
    wait_fr(g);
    wait_fr(h);
    chk((g ^ h) === 9'h003, "both frames");
  endtask : t_fill
  task automatic t_age;
    logic [8:0] g;
    cyc(4300);
    mk(STA, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h00e, "aged entry");
  endtask : t_age
  task automatic t_loss;
    logic [8:0] g;
    link_en <= 8'h07;
    cyc(300);
    chk(link_up === 8'h07, "link lost");
    mk(BC, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h006, "dead port skipped");
  endtask : t_loss
  task automatic t_reset;
    logic [8:0] g;
    mk(BC, STA, 64, 1'b0);
    send(1);
    wait_fr(g);
    chk(g === 9'h005, "relearn");
    rst <= 1'b1;
    cyc(4);
    rst <= 1'b0;
    cyc(120);
    chk(link_up === 8'h07, "links after reset");
    mk(STA, SA0, 64, 1'b0);
    send(0);
    wait_fr(g);
    chk(g === 9'h006, "table cleared");
  endtask : t_reset

  initial
  begin
    cyc(4);
    rst <= 1'b0;
    t_link();
    t_len();
    t_learn();
    t_tag();
    t_fill();
    t_age();
    t_loss();
    t_reset();
    end_sim();
  end
endmodule : esw_switch_core_bench
